// ---- inc/fldiag_defines.svh ----
// constants of the fault lamp diagnostic block: offsets, fields, resets, timing
// assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus
`ifndef FLDIAG_DEFINES_SVH
`define FLDIAG_DEFINES_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FL_OFS_CTRL 8'h00
`define FL_OFS_FAULT 8'h04
`define FL_OFS_CMD 8'h08
`define FL_OFS_CODES 8'h0c
`define FL_OFS_SNAP 8'h10
`define FL_OFS_STATUS 8'h14
`define FL_OFS_READY 8'h18
`define FL_OFS_TESTVAL 8'h1c
`define FL_OFS_DIST 8'h20
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FL_CTRL_MODE 0
`define FL_CMD_TRIP 0
`define FL_CMD_ERASE 1
`define FL_CMD_ODO 2
`define FL_RST_WORD16 16'h0000
`define FL_NO_FAULT_CODE 16'h0000
`define FL_ZERO_BLINKS 4'ha
// ----------------------------------------------------------------
// timing: times in ms, counts derived from them
// ----------------------------------------------------------------
`define FL_CLK_HZ 10000000
`define FL_TICK_MS 100
`define FL_TICK_CYCLES (`FL_CLK_HZ / 1000 * `FL_TICK_MS)
`define FL_T_THOU_MS 600
`define FL_T_LOW_MS 300
`define FL_T_DGAP_MS 1000
`define FL_T_CGAP_MS 1800
`define FL_TK_THOU (`FL_T_THOU_MS / `FL_TICK_MS)
`define FL_TK_LOW (`FL_T_LOW_MS / `FL_TICK_MS)
`define FL_TK_DGAP (`FL_T_DGAP_MS / `FL_TICK_MS)
`define FL_TK_CGAP (`FL_T_CGAP_MS / `FL_TICK_MS)
`endif

// ---- inc/fldiag_pkg.sv ----
// types shared by the fault lamp diagnostic block
// assumes nothing beyond a SystemVerilog compiler
package fldiag_pkg;
  // readout sequencer states, one-hot
  typedef enum logic [4:0] {
    FL_S_IDLE = 5'b00001,
    FL_S_ON = 5'b00010,
    FL_S_OFF = 5'b00100,
    FL_S_DGAP = 5'b01000,
    FL_S_CGAP = 5'b10000
  } fldiag_state_t;
endpackage

// ---- rtl/fldiag_store.sv ----
// trouble code memory: one pending code, one confirmed code, one snapshot slot
// assumes one-cycle detect, trip and erase pulses on the system clock
`timescale 1ns/1ps
module fldiag_store (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // events
  input wire logic detect,
  input wire logic [15:0] code,
  input wire logic [15:0] frame,
  input wire logic trip,
  input wire logic erase,
  // stored state
  output logic conf_valid,
  output logic [15:0] conf_code,
  output logic pend_valid,
  output logic [15:0] pend_code,
  output logic snap_valid,
  output logic snap_conf,
  output logic [15:0] snap_data
);
  logic pend_old_r; // pending code survived a trip boundary
  logic same;
  assign same = pend_valid && (code == pend_code);
  // one slot shared by both snapshot kinds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conf_valid <= 1'b0;
      conf_code <= 16'h0000;
      pend_valid <= 1'b0;
      pend_code <= 16'h0000;
      pend_old_r <= 1'b0;
      snap_valid <= 1'b0;
      snap_conf <= 1'b0;
      snap_data <= 16'h0000;
    end else if (erase) begin
      // detection in the erase cycle wins and starts afresh
      conf_valid <= 1'b0; // RQ5
      conf_code <= 16'h0000;
      pend_valid <= detect;
      pend_code <= detect ? code : 16'h0000;
      pend_old_r <= 1'b0;
      snap_valid <= detect;
      snap_conf <= 1'b0;
      snap_data <= detect ? frame : 16'h0000;
    end else if (detect && same && pend_old_r) begin
      // second consecutive trip: confirm, first confirmed frame kept
      if (!conf_valid) begin
        conf_valid <= 1'b1; // RQ22
        conf_code <= code;
        snap_valid <= 1'b1; // RQ1
        snap_conf <= 1'b1;
        snap_data <= frame;
      end // RQ4
    end else if (detect && !same) begin
      pend_valid <= 1'b1; // RQ22
      pend_code <= code;
      pend_old_r <= 1'b0;
      if (!snap_conf) begin
        snap_valid <= 1'b1; // RQ2
        snap_data <= frame;
      end // RQ3
    end else if (trip) begin
      pend_old_r <= pend_valid;
    end
  end
endmodule

// ---- rtl/fldiag_tick.sv ----
// time base: one-cycle pulse every CYCLES clocks
// assumes a synchronous clear from the readout sequencer
`timescale 1ns/1ps
module fldiag_tick #(
  parameter int unsigned CYCLES = 1000000
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control and pulse
  input wire logic clr,
  output logic tick
);
  localparam int unsigned W = $clog2(CYCLES);
  initial begin
    if (CYCLES < 2) $error("fldiag_tick: CYCLES must be at least 2");
  end
  logic [W-1:0] cnt_r; // cycles into the current tick
  // divider; clear realigns so the first phase is full length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else if (clr) begin
      cnt_r <= W'(1); // the clearing cycle counts as the first of the tick
      tick <= 1'b0;
    end else if (cnt_r == W'(CYCLES - 1)) begin
      cnt_r <= '0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// ---- rtl/fldiag_top.sv ----
// fault lamp diagnostic block: AHB-Lite registers, mode logic, blink readout
// assumes engine pins are asynchronous and software reports fault events
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fldiag_defines.svh"
// How it works
// [RQ1] one snapshot slot for both kinds
// [RQ2] pending snapshot replaced by each new code
// [RQ3] confirmed snapshot blocks further pending snapshots
// [RQ4] first confirmed snapshot kept, later discarded
// [RQ5] erase clears codes and both snapshots
// [RQ6] erase clears readiness, test values, distance
// [RQ7] leaving readout mode erases stored codes
// [RQ8] normal mode, engine stopped: lamp on
// [RQ9] normal mode running: off without malfunction
// [RQ10] warning lamp on for malfunction or cpu fault
// [RQ11] readout shows confirmed and pending codes together
// [RQ12] four digits, most significant first, blinked
// [RQ13] zero digit shown as ten blinks
// [RQ14] thousands blinks 0.6 s on, 0.6 s off
// [RQ15] lower digit blinks 0.3 s on, off
// [RQ16] 1.0 s dark between digits
// [RQ17] 1.8 s dark between codes
// [RQ18] no stored fault shows code 0000
// [RQ19] running readout: lamp follows lean sensor
// [RQ20] open loop freezes lamp state
// [RQ21] healthy sensor toggles lamp often enough
// [RQ22] pending first trip, confirmed second trip
// [RQ23] readout sequence repeats from first code
// [RQ24] timing from 0.1 s tick counter
module fldiag_top #(
  parameter int unsigned TICK_CYCLES = `FL_TICK_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // engine pins, asynchronous
  input wire logic ignition_on,
  input wire logic engine_running,
  input wire logic cpu_fault,
  input wire logic o2_lean,
  input wire logic closed_loop,
  // lamp
  output logic fault_lamp
);
  import fldiag_pkg::*;
  initial begin
    if (TICK_CYCLES < 2) $error("fldiag_top: TICK_CYCLES must be at least 2");
  end
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_meta_r; // first stage, read only by second
  logic [4:0] pin_r; // synchronised pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_r <= 5'h00;
      pin_r <= 5'h00;
    end else begin
      pin_meta_r <= {closed_loop, o2_lean, cpu_fault, engine_running, ignition_on};
      pin_r <= pin_meta_r;
    end
  end
  logic ign, run, cpuf, lean, cloop;
  assign {cloop, lean, cpuf, run, ign} = pin_r;
  // ----------------------------------------------------------------
  // ahb-lite slave: zero wait, always okay
  // ----------------------------------------------------------------
  logic dp_wr_r; // write data phase pending
  logic [7:0] dp_addr_r; // address of that phase
  logic addr_ok;
  logic [31:0] rd_nxt;
  assign addr_ok = hsel && htrans[1] && hready;
  // capture address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r <= addr_ok && hwrite;
      dp_addr_r <= haddr[7:0];
    end
  end
  // fixed handshake outputs from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  logic wr_ctrl, wr_fault, wr_cmd, wr_ready, wr_test;
  assign wr_ctrl = dp_wr_r && (dp_addr_r == `FL_OFS_CTRL);
  assign wr_fault = dp_wr_r && (dp_addr_r == `FL_OFS_FAULT);
  assign wr_cmd = dp_wr_r && (dp_addr_r == `FL_OFS_CMD);
  assign wr_ready = dp_wr_r && (dp_addr_r == `FL_OFS_READY);
  assign wr_test = dp_wr_r && (dp_addr_r == `FL_OFS_TESTVAL);
  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic mode_r; // 1: code readout mode
  logic [15:0] ready_r; // readiness test codes
  logic [15:0] testval_r; // stored test value
  logic [15:0] dist_r; // distance units with lamp lit
  logic erase; // memory erase pulse
  logic mode_leave;
  assign mode_leave = wr_ctrl && mode_r && !hwdata[`FL_CTRL_MODE];
  assign erase = (wr_cmd && hwdata[`FL_CMD_ERASE]) || mode_leave; // RQ7
  // mode select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= 1'b0;
    end else if (wr_ctrl) begin
      mode_r <= hwdata[`FL_CTRL_MODE];
    end
  end
  // erase clears the side data; a write in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_r <= `FL_RST_WORD16;
      testval_r <= `FL_RST_WORD16;
      dist_r <= `FL_RST_WORD16;
    end else begin
      if (wr_ready) begin
        ready_r <= hwdata[15:0];
      end else if (erase) begin
        ready_r <= `FL_RST_WORD16; // RQ6
      end
      if (wr_test) begin
        testval_r <= hwdata[15:0];
      end else if (erase) begin
        testval_r <= `FL_RST_WORD16; // RQ6
      end
      // erase beats a distance step so a combined command leaves zero
      if (erase) begin
        dist_r <= `FL_RST_WORD16; // RQ6
      end else if (wr_cmd && hwdata[`FL_CMD_ODO] && fault_lamp) begin
        dist_r <= dist_r + 16'h0001;
      end
    end
  end
  // ----------------------------------------------------------------
  // code memory
  // ----------------------------------------------------------------
  logic conf_valid, pend_valid, snap_valid, snap_conf;
  logic [15:0] conf_code, pend_code, snap_data;
  fldiag_store u_store (
    .hclk(hclk),
    .hresetn(hresetn),
    .detect(wr_fault),
    .code(hwdata[15:0]),
    .frame(hwdata[31:16]),
    .trip(wr_cmd && hwdata[`FL_CMD_TRIP]),
    .erase(erase),
    .conf_valid(conf_valid),
    .conf_code(conf_code),
    .pend_valid(pend_valid),
    .pend_code(pend_code),
    .snap_valid(snap_valid),
    .snap_conf(snap_conf),
    .snap_data(snap_data)
  );
  // ----------------------------------------------------------------
  // blink readout sequencer
  // ----------------------------------------------------------------
  fldiag_state_t st_r; // sequencer state
  logic [4:0] tcnt_r; // ticks in current phase
  logic [3:0] blinks_r; // blinks left in digit
  logic [1:0] dig_r; // digit index, 0 = thousands
  logic cidx_r; // code index
  logic tick, ph_end, rd_act, two_codes;
  logic [15:0] first_code, cur_code, next_code;
  logic [4:0] dur;
  assign rd_act = mode_r && ign && !run;
  // confirmed first, else pending, else the all-clear code; distinct pending second
  assign two_codes = conf_valid && pend_valid && (pend_code != conf_code); // RQ11
  assign first_code = conf_valid ? conf_code :
                      (pend_valid ? pend_code : `FL_NO_FAULT_CODE); // RQ18
  assign cur_code = cidx_r ? pend_code : first_code;
  assign next_code = (cidx_r || !two_codes) ? first_code : pend_code; // RQ23
  fldiag_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(st_r == FL_S_IDLE), // RQ24
    .tick(tick)
  );
  // blink count of one digit, zero shown as ten
  function automatic logic [3:0] blinks_of(input logic [15:0] c, input logic [1:0] i);
    logic [3:0] d;
    d = c[4'(12 - 4 * i) +: 4]; // RQ12
    blinks_of = (d == 4'h0) ? `FL_ZERO_BLINKS : d; // RQ13
  endfunction
  // phase length in ticks
  always_comb begin
    dur = 5'd1;
    case (st_r)
      FL_S_ON, FL_S_OFF: dur = (dig_r == 2'd0) ? 5'(`FL_TK_THOU) : 5'(`FL_TK_LOW); // RQ14 RQ15
      FL_S_DGAP: dur = 5'(`FL_TK_DGAP); // RQ16
      FL_S_CGAP: dur = 5'(`FL_TK_CGAP); // RQ17
      default: dur = 5'd1;
    endcase
  end
  assign ph_end = tick && (tcnt_r == dur - 5'd1);
  // phase tick counter, restarts with each phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcnt_r <= 5'd0;
    end else if (!rd_act || ph_end || st_r == FL_S_IDLE) begin
      tcnt_r <= 5'd0;
    end else if (tick) begin
      tcnt_r <= tcnt_r + 5'd1;
    end
  end
  // sequencer: on, off, then digit gap or code gap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= FL_S_IDLE;
      blinks_r <= 4'h0;
      dig_r <= 2'd0;
      cidx_r <= 1'b0;
    end else if (!rd_act) begin
      st_r <= FL_S_IDLE; // leaving readout aborts the sequence
    end else begin
      case (st_r)
        FL_S_IDLE: begin
          st_r <= FL_S_ON;
          dig_r <= 2'd0;
          cidx_r <= 1'b0;
          blinks_r <= blinks_of(first_code, 2'd0);
        end
        FL_S_ON: if (ph_end) begin
          st_r <= FL_S_OFF;
        end
        FL_S_OFF: if (ph_end) begin
          if (blinks_r > 4'h1) begin
            blinks_r <= blinks_r - 4'h1;
            st_r <= FL_S_ON;
          end else if (dig_r != 2'd3) begin
            st_r <= FL_S_DGAP; // RQ16
          end else begin
            st_r <= FL_S_CGAP; // RQ17
          end
        end
        FL_S_DGAP: if (ph_end) begin
          dig_r <= dig_r + 2'd1;
          blinks_r <= blinks_of(cur_code, dig_r + 2'd1); // RQ12
          st_r <= FL_S_ON;
        end
        FL_S_CGAP: if (ph_end) begin
          cidx_r <= two_codes && !cidx_r; // RQ23
          dig_r <= 2'd0;
          blinks_r <= blinks_of(next_code, 2'd0);
          st_r <= FL_S_ON;
        end
        default: st_r <= FL_S_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // lamp driver
  // ----------------------------------------------------------------
  logic o2_hold_r; // lamp state from last closed-loop sample
  logic malf;
  assign malf = conf_valid || cpuf;
  // capture sensor state only while closed loop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      o2_hold_r <= 1'b0;
    end else if (cloop) begin
      o2_hold_r <= lean; // RQ20
    end
  end
  // lamp by mode and engine state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_lamp <= 1'b0;
    end else if (!ign) begin
      fault_lamp <= 1'b0;
    end else if (!mode_r) begin
      fault_lamp <= run ? malf : 1'b1; // RQ8 RQ9 RQ10
    end else if (!run) begin
      fault_lamp <= (st_r == FL_S_ON); // RQ11
    end else begin
      fault_lamp <= cloop ? lean : o2_hold_r; // RQ19 RQ20 RQ21
    end
  end
  // ----------------------------------------------------------------
  // read mux, registered into the data phase
  // ----------------------------------------------------------------
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (haddr[7:0])
      `FL_OFS_CTRL: rd_nxt = {31'h0, mode_r};
      `FL_OFS_CODES: rd_nxt = {pend_code, conf_code};
      `FL_OFS_SNAP: rd_nxt = {16'h0000, snap_data};
      `FL_OFS_STATUS: rd_nxt = {17'h0, st_r, pin_r, fault_lamp, snap_conf, snap_valid,
                                pend_valid, conf_valid};
      `FL_OFS_READY: rd_nxt = {16'h0000, ready_r};
      `FL_OFS_TESTVAL: rd_nxt = {16'h0000, testval_r};
      `FL_OFS_DIST: rd_nxt = {16'h0000, dist_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_on_end;
    st_r == FL_S_ON && ph_end;
  endsequence
  sequence s_last_off_end;
    st_r == FL_S_OFF && ph_end && blinks_r == 4'h1;
  endsequence
  a_bulb_check_on: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
    (!mode_r && ign && !run) |=> fault_lamp) else $error("bulb check lamp off");
  a_run_lamp_off: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
    (!mode_r && ign && run && !malf) |=> !fault_lamp) else $error("lamp on without fault");
  a_malf_lamp_on: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
    (!mode_r && ign && run && malf) |=> fault_lamp) else $error("fault lamp not lit");
  a_blink_on_off: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    (rd_act and s_on_end) |=> st_r == FL_S_OFF) else $error("on phase not ended");
  a_thou_len: assert property (@(posedge hclk) disable iff (!hresetn) // RQ15
    (st_r == FL_S_ON) |-> dur == ((dig_r == 2'd0) ? 5'd6 : 5'd3)) else $error("blink length");
  a_digit_gap: assert property (@(posedge hclk) disable iff (!hresetn) // RQ16
    (s_last_off_end and (rd_act && dig_r != 2'd3)) |=> (st_r == FL_S_DGAP && dur == 5'd10))
    else $error("digit gap wrong");
  a_code_gap: assert property (@(posedge hclk) disable iff (!hresetn) // RQ17
    (s_last_off_end and (rd_act && dig_r == 2'd3)) |=> (st_r == FL_S_CGAP && dur == 5'd18))
    else $error("code gap wrong");
  a_zero_ten: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
    (rd_act && st_r == FL_S_IDLE && first_code[15:12] == 4'h0) |=> blinks_r == 4'ha)
    else $error("zero digit not ten blinks");
  a_open_loop_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RQ20
    (mode_r && ign && run && !cloop) ##1 (mode_r && ign && run && !cloop)
    |=> $stable(fault_lamp)) else $error("lamp moved in open loop");
  a_conf_kept: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
    (conf_valid && !erase) |=> (conf_valid && $stable(conf_code))) else $error("confirmed lost");
  a_erase_clears: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
    (erase && !wr_fault) |=> (!conf_valid && !pend_valid && !snap_valid && dist_r == 16'h0))
    else $error("erase incomplete");
  a_mode_leave_erase: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
    (mode_r && wr_ctrl && !hwdata[`FL_CTRL_MODE])
    |=> (!conf_valid && !pend_valid && !snap_valid)) else $error("mode change no erase");
endmodule

// ---- tb/fldiag_lamp_obs.sv ----
// lamp watcher: records width of the first 64 lit and dark pulses in clocks
// assumes the lamp is a clean level output sampled on the system clock
`timescale 1ns/1ps
module fldiag_lamp_obs (
  // clock and restart
  input wire logic hclk,
  input wire logic clr,
  // lamp as the technician sees it
  input wire logic fault_lamp,
  // measurements
  output int rises,
  output int on_w[64],
  output int off_w[64]
);
  logic prev; // lamp level one clock ago
  int len; // clocks since the last change
  // ------------------------------------------------------------
  // width capture; dark time before the first blink is not kept
  // ------------------------------------------------------------
  always @(posedge hclk) begin
    if (clr) begin
      rises = 0;
      len = 0;
      prev = 1'b0;
    end else begin
      len = len + 1;
      if (fault_lamp !== prev) begin
        // lamp came on: closes the dark span after pulse rises-1
        if (fault_lamp === 1'b1) begin
          if (rises > 0 && rises < 65) off_w[rises-1] = len;
          rises = rises + 1;
        end else if (rises > 0 && rises < 65) begin
          on_w[rises-1] = len;
        end
        len = 0;
        prev = fault_lamp;
      end
    end
  end
endmodule

// ---- tb/tb_fldiag_top.sv ----
// self-checking bench of the lamp diagnostic block over its ahb-lite port
// assumes a single zero-wait slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
`include "fldiag_defines.svh"
module tb_fldiag_top;
  localparam int TK = 10; // short tick so blink runs stay brief
  logic hclk, hresetn, hsel, hwrite, obs_clr;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, fault_lamp;
  logic [4:0] pin; // {closed_loop, o2_lean, cpu_fault, engine_running, ignition_on}
  int miscompares, num_checks, cyc, rises, i;
  int on_w[64], off_w[64];
  logic [7:0] clr_ofs[5];
  fldiag_top #(.TICK_CYCLES(TK)) fldiag_top_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ignition_on(pin[0]), .engine_running(pin[1]), .cpu_fault(pin[2]),
    .o2_lean(pin[3]), .closed_loop(pin[4]), .fault_lamp(fault_lamp));
  fldiag_lamp_obs fldiag_lamp_obs_i (.hclk(hclk), .clr(obs_clr), .fault_lamp(fault_lamp),
    .rises(rises), .on_w(on_w), .off_w(off_w));
  // ------------------------------------------------------------
  // clock, reset and hang guard
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ------------------------------------------------------------
  // bus master: address phase held until hready, then data phase
  // ------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask
  // pins pass a two-stage synchroniser plus the lamp flop
  task automatic pins(input logic [4:0] p);
    @(posedge hclk);
    pin <= p;
    repeat (5) @(posedge hclk);
  endtask
  // restart the watcher with the lamp dark, then start the readout
  task automatic start_readout();
    pins(5'h00);
    wr(`FL_OFS_CTRL, 32'h1);
    @(posedge hclk);
    obs_clr <= 1'b1;
    @(posedge hclk);
    obs_clr <= 1'b0;
    pins(5'h01);
  endtask
  // expected widths worked out digit by digit from the two codes
  task automatic chk_blinks(input logic [15:0] c0, input logic [15:0] c1, input int nc,
                            input int np);
    int k, n, w, ci, di, b, gap;
    logic [15:0] c;
    k = 0;
    ci = 0;
    for (i = 0; i < 30000 && rises <= np; i++) @(posedge hclk);
    while (k < np) begin
      c = (ci % nc == 0) ? c0 : c1;
      for (di = 3; di >= 0; di--) begin
        n = (c[di*4 +: 4] == 4'h0) ? 10 : c[di*4 +: 4];
        w = (di == 3) ? 6 : 3;
        for (b = 0; b < n; b++) begin
          gap = (b == n - 1) ? ((di == 0) ? 18 : 10) : 0;
          if (k < np) begin
            chk("lit width", on_w[k], w * TK);
            chk("dark width", off_w[k], (w + gap) * TK);
          end
          k++;
        end
      end
      ci++;
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    hresetn = 1'b0;
    {hsel, hwrite, obs_clr} = 3'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    pin = 5'h00;
    clr_ofs = '{`FL_OFS_CODES, `FL_OFS_SNAP, `FL_OFS_READY, `FL_OFS_TESTVAL, `FL_OFS_DIST};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("status rst", `FL_OFS_STATUS, 32'h400);
    wr(8'h40, 32'hffff_ffff);
    rdchk("unmapped", 8'h40, 32'h0);
    pins(5'h01);
    chk("bulb", fault_lamp, 1'b1);
    pins(5'h03);
    chk("run ok", fault_lamp, 1'b0);
    pins(5'h07);
    chk("cpu", fault_lamp, 1'b1);
    pins(5'h03);
    wr(`FL_OFS_FAULT, 32'haaaa_1203);
    rdchk("codes", `FL_OFS_CODES, 32'h1203_0000);
    wr(`FL_OFS_FAULT, 32'hbbbb_2001);
    rdchk("codes", `FL_OFS_CODES, 32'h2001_0000);
    rdchk("snap", `FL_OFS_SNAP, 32'hbbbb);
    wr(`FL_OFS_CMD, 32'h1);
    wr(`FL_OFS_FAULT, 32'hcccc_2001);
    rdchk("codes", `FL_OFS_CODES, 32'h2001_2001);
    rdchk("snap", `FL_OFS_SNAP, 32'hcccc);
    chk("conf lamp", fault_lamp, 1'b1);
    wr(`FL_OFS_FAULT, 32'hdddd_1203);
    rdchk("snap", `FL_OFS_SNAP, 32'hcccc);
    wr(`FL_OFS_CMD, 32'h1);
    wr(`FL_OFS_FAULT, 32'heeee_1203);
    rdchk("codes", `FL_OFS_CODES, 32'h1203_2001);
    rdchk("snap", `FL_OFS_SNAP, 32'hcccc);
    start_readout();
    chk_blinks(16'h2001, 16'h1203, 2, 41);
    pins(5'h00);
    wr(`FL_OFS_CTRL, 32'h0);
    rdchk("codes", `FL_OFS_CODES, 32'h0);
    pins(5'h07);
    wr(`FL_OFS_READY, 32'h1234);
    wr(`FL_OFS_TESTVAL, 32'h5678);
    wr(`FL_OFS_CMD, 32'h4);
    wr(`FL_OFS_CMD, 32'h4);
    rdchk("dist", `FL_OFS_DIST, 32'h2);
    rdchk("ready", `FL_OFS_READY, 32'h1234);
    rdchk("testval", `FL_OFS_TESTVAL, 32'h5678);
    wr(`FL_OFS_FAULT, 32'h1111_0450);
    wr(`FL_OFS_CMD, 32'h2);
    for (int j = 0; j < 5; j++) rdchk("erased", clr_ofs[j], 32'h0);
    rdchk("status", `FL_OFS_STATUS, 32'h0000_0410 | 32'h0000_0e0);
    start_readout();
    chk_blinks(16'h0000, 16'h0000, 1, 14);
    pins(5'h1b);
    chk("lean", fault_lamp, 1'b1);
    pins(5'h13);
    chk("rich", fault_lamp, 1'b0);
    pins(5'h1b);
    pins(5'h0b);
    pins(5'h03);
    chk("frozen", fault_lamp, 1'b1);
    pins(5'h13);
    obs_clr <= 1'b1;
    @(posedge hclk);
    obs_clr <= 1'b0;
    for (int j = 0; j < 6; j++) begin
      pins(5'h1b);
      pins(5'h13);
    end
    chk("turn ons", {31'h0, rises > 5}, 32'h1);
    end_of_test();
  end
endmodule
